/* File: core/gccc_map.vh */
// Constants for the gated clock and cycle counter
`ifndef GCCC_MAP_VH
`define GCCC_MAP_VH
// Bus command codes (esd values)
`define GCCC_CMD_ARM 12'h7F0
`define GCCC_CMD_OPEN 12'h7E0
`define GCCC_CMD_STOP 12'h7E1
`define GCCC_CMD_OUT_EN 12'h7D0
`define GCCC_CMD_SHIFT_CYC 12'h7C0
`define GCCC_CMD_COPY_CLK1 12'h7B0
`define GCCC_CMD_COPY_CLK2 12'h7A0
// Counter geometry
`define GCCC_CLK_W 11
`define GCCC_CYC_W 5
`define GCCC_STAGE_W 4
// Reset values
`define GCCC_CLK_RST 11'h000
`define GCCC_CYC_RST 5'h00
`endif

/* File: core/gccc_counter.v */
// Gated clock counter and cycle counter with readback shift chain
`timescale 1ns/10ps
`include "gccc_map.vh"

// Summary of operation
// - Open command enables voltmeter gate in voltmeter mode
// - Voltmeter gate passes only when mode flag set
// - Conversion done high blocks further clock pulses in voltmeter mode
// - Cycle counter divides selected input by 32
// - Cycle counter shares frequency gate, cleared together
// - Cycle carries drive readback line three low
// - Cycle and clock carry drivers enabled together
// - First readback enables outputs, shows cycle high stage
// - Second readback loads high stage from low
// - Third, fourth copy clock stages along chain
// - Clock counter divides 2 MHz by 2048
// - Arm clears frequency gate and both counters
// - Final clock stage carries drive readback line two
// - Frequency gate follows open request on falling input edges
module gccc_counter (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire i_ce,
  input wire i_cmd_valid,
  input wire [11:0] i_cmd_code,
  input wire i_mode_select_flag,
  input wire i_freq_mux_input,
  input wire i_conversion_done,
  output reg [3:0] o_readback_d_n,
  output reg [3:0] o_readback_oe,
  output wire o_gate_active,
  output wire [10:0] o_clock_count,
  output wire [4:0] o_cycle_count
);

  // ==========================================================
  // Input synchronisers and edge history
  reg freq_mux_input_s1_reg, freq_mux_input_s2_reg, freq_mux_input_s3_reg;
  reg done_s1_reg, done_s2_reg;
  wire freq_mux_input_fall = freq_mux_input_s3_reg & ~freq_mux_input_s2_reg;

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      freq_mux_input_s1_reg <= 1'b0;
      freq_mux_input_s2_reg <= 1'b0;
      freq_mux_input_s3_reg <= 1'b0;
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
    end else if (i_ce) begin
      freq_mux_input_s1_reg <= i_freq_mux_input;
      freq_mux_input_s2_reg <= freq_mux_input_s1_reg;
      freq_mux_input_s3_reg <= freq_mux_input_s2_reg;
      done_s1_reg <= i_conversion_done;
      done_s2_reg <= done_s1_reg;
    end
  end

  // ==========================================================
  // Command decode
  function cmd_is;
    input valid;
    input [11:0] code;
    input [11:0] want;
    begin
      cmd_is = valid & (code == want);
    end
  endfunction

  wire c_arm = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_ARM);
  wire c_open = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_OPEN);
  wire c_stop = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_STOP);
  wire c_oen = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_OUT_EN);
  wire c_sh_cyc = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_SHIFT_CYC);
  wire c_cp1 = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_COPY_CLK1);
  wire c_cp2 = cmd_is(i_cmd_valid, i_cmd_code, `GCCC_CMD_COPY_CLK2);

  // ==========================================================
  // Gate control
  reg open_req_reg;     // Gate-open request (open command latch)
  reg freq_gate_reg;    // Frequency gate, follows request on FREQ_MUX_INPUT fall
  reg output_enable_latch_reg;
  reg carry_en_reg;

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      open_req_reg <= 1'b0;
      freq_gate_reg <= 1'b0;
      output_enable_latch_reg <= 1'b0;
      carry_en_reg <= 1'b0;
    end else if (i_ce) begin
      if (c_arm) begin
        open_req_reg <= 1'b0;
        freq_gate_reg <= 1'b0;
        output_enable_latch_reg <= 1'b0;
      end else if (c_open) begin
        open_req_reg <= 1'b1;
        carry_en_reg <= 1'b1;
        output_enable_latch_reg <= 1'b0;
      end else if (c_stop) begin
        open_req_reg <= 1'b0;
      end else if (c_oen) begin
        output_enable_latch_reg <= 1'b1;
        carry_en_reg <= 1'b0;
      end
      if (freq_mux_input_fall && !c_arm) begin
        freq_gate_reg <= open_req_reg & ~i_mode_select_flag;
      end
    end
  end

  wire voltmeter_gate = open_req_reg & i_mode_select_flag & ~done_s2_reg;
  wire frequency_gate = freq_gate_reg & ~i_mode_select_flag;
  assign o_gate_active = voltmeter_gate | frequency_gate;

  // ==========================================================
  // Clock counter (3 stages) and cycle counter (2 stages)
  reg [10:0] clk_cnt_reg;
  reg [4:0] cyc_cnt_reg;
  reg clk_carry_reg, cyc_carry_reg;
  wire [3:0] clock_stage_first = clk_cnt_reg[3:0];
  wire [3:0] clock_stage_second = clk_cnt_reg[7:4];
  wire [3:0] cycle_stage_high = {3'h0, cyc_cnt_reg[4]};
  wire [3:0] cycle_stage_low = cyc_cnt_reg[3:0];
  reg [3:0] chain_reg;  // Final output stage of the readback chain

  // ==========================================================
  // Readback nibble selection
  // The chain register and the line drivers both need the nibble
  // picked by the current readback command, so the choice lives in
  // one function and both sides stay in step. With no readback
  // command the chain keeps the nibble of the previous command, so
  // a controller that samples late still sees the right stage.
  function [3:0] readback_nibble;
    input oen;
    input sh_cyc;
    input cp1;
    input cp2;
    input [3:0] hi_cyc;
    input [3:0] lo_cyc;
    input [3:0] clk_first;
    input [3:0] clk_second;
    input [3:0] held;
    begin
      if (oen) begin
        readback_nibble = hi_cyc;
      end else if (sh_cyc) begin
        readback_nibble = lo_cyc;
      end else if (cp1) begin
        readback_nibble = clk_first;
      end else if (cp2) begin
        readback_nibble = clk_second;
      end else begin
        readback_nibble = held;
      end
    end
  endfunction

  // Clock bits 10:8 are never read back; the controller keeps the
  // count above bit 10 only, from the carries it tallied.
  wire [3:0] next_nibble = readback_nibble(c_oen, c_sh_cyc, c_cp1, c_cp2, cycle_stage_high, cycle_stage_low,
                                           clock_stage_first, clock_stage_second, chain_reg);

  // ==========================================================
  // Counting and readback chain

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      clk_cnt_reg <= `GCCC_CLK_RST;
      cyc_cnt_reg <= `GCCC_CYC_RST;
      clk_carry_reg <= 1'b0;
      cyc_carry_reg <= 1'b0;
      chain_reg <= 4'h0;
    end else if (i_ce) begin
      clk_carry_reg <= 1'b0;
      cyc_carry_reg <= 1'b0;
      if (c_arm) begin
        clk_cnt_reg <= `GCCC_CLK_RST;
        cyc_cnt_reg <= `GCCC_CYC_RST;
      end else begin
        if (o_gate_active) begin
          clk_cnt_reg <= clk_cnt_reg + 11'h001;
          clk_carry_reg <= &clk_cnt_reg;
        end
        if (frequency_gate && freq_mux_input_fall) begin
          cyc_cnt_reg <= cyc_cnt_reg + 5'h01;
          cyc_carry_reg <= &cyc_cnt_reg;
        end
      end
      chain_reg <= next_nibble;
    end
  end

  assign o_clock_count = clk_cnt_reg;
  assign o_cycle_count = cyc_cnt_reg;

  // ==========================================================
  // Readback line drivers (active low, released when idle)
  // Open and arm override a stale output latch, and open raises the
  // carry drivers in the cycle right after the command, so no carry
  // that follows the open command can be lost.
  wire out_mode = (output_enable_latch_reg | c_oen) & ~c_open & ~c_arm;
  wire carry_on = (carry_en_reg | c_open) & ~c_oen;

  always @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      o_readback_d_n <= 4'hF;
      o_readback_oe <= 4'h0;
    end else if (i_ce) begin
      if (out_mode) begin
        o_readback_oe <= 4'hF;
        o_readback_d_n <= ~next_nibble;
      end else begin
        o_readback_oe <= {carry_on, carry_on, 2'b00};
        o_readback_d_n <= {~cyc_carry_reg, ~clk_carry_reg, 2'b11};
      end
    end
  end

endmodule

/* File: tb/gccc_counter_assertions.sv */
// Concurrent checks on the gated clock and cycle counter ports
`timescale 1ns/10ps
`include "gccc_map.vh"
module gccc_counter_assertions (
  input wire I_CLK_SYS,
  input wire I_RESET,
  input wire i_ce,
  input wire i_cmd_valid,
  input wire [11:0] i_cmd_code,
  input wire [3:0] o_readback_d_n,
  input wire [3:0] o_readback_oe,
  input wire o_gate_active,
  input wire [10:0] o_clock_count,
  input wire [4:0] o_cycle_count
);
  // ==========
  // Properties
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);
  sequence s_cmd(c); i_cmd_valid && i_ce && i_cmd_code == c; endsequence
  property p_rst; disable iff (1'b0) I_RESET && i_ce |=> o_clock_count == 11'h000 && o_readback_oe == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_inc; o_gate_active && i_ce && !i_cmd_valid |=> o_clock_count == $past(o_clock_count) + 11'h001; endproperty
  a_inc: assert property (p_inc) else $error("clock count step wrong");
  property p_hold; !o_gate_active && !i_cmd_valid |=> $stable(o_clock_count); endproperty
  a_hold: assert property (p_hold) else $error("count moved while gated");
  property p_arm; s_cmd(`GCCC_CMD_ARM) |=> o_clock_count == 11'h000 && o_cycle_count == 5'h00; endproperty
  a_arm: assert property (p_arm) else $error("arm did not clear");
  property p_open; s_cmd(`GCCC_CMD_OPEN) |=> o_readback_oe == 4'hC; endproperty
  a_open: assert property (p_open) else $error("carry drivers wrong");
  property p_oen; s_cmd(`GCCC_CMD_OUT_EN) |=> o_readback_oe == 4'hF && o_readback_d_n == {3'h7, !$past(o_cycle_count[4])}; endproperty
  a_oen: assert property (p_oen) else $error("output enable wrong");
  property p_sh; s_cmd(`GCCC_CMD_SHIFT_CYC) |=> o_readback_d_n == ~$past(o_cycle_count[3:0]); endproperty
  a_sh: assert property (p_sh) else $error("cycle shift wrong");
  property p_cp; s_cmd(`GCCC_CMD_COPY_CLK1) |=> o_readback_d_n == ~$past(o_clock_count[3:0]); endproperty
  a_cp: assert property (p_cp) else $error("clock copy wrong");
endmodule

/* File: tb/gccc_ctrl_model.sv */
// Controller model: issues bus commands and tallies carries
`timescale 1ns/10ps
module gccc_ctrl_model (
  input wire I_CLK_SYS,
  input wire [3:0] i_d_n,
  input wire [3:0] i_oe,
  output reg o_valid = 1'b0,
  output reg [11:0] o_code = 12'h000
);
  // ==========
  // Commands and carry tally
  integer clk_carries = 0;
  integer cyc_carries = 0;
  task send(input [11:0] c);
    begin
      o_valid <= 1'b1;
      o_code <= c;
      @(posedge I_CLK_SYS);
      o_valid <= 1'b0;
      @(posedge I_CLK_SYS);
    end
  endtask
  always @(posedge I_CLK_SYS) begin
    clk_carries <= clk_carries + (i_oe == 4'hC && !i_d_n[2]);
    cyc_carries <= cyc_carries + (i_oe == 4'hC && !i_d_n[3]);
  end
endmodule

/* File: tb/test_gccc_counter.sv */
// Self-checking bench for the gated clock and cycle counter
`timescale 1ns/10ps
`include "gccc_map.vh"
module test_gccc_counter;
  reg I_CLK_SYS = 1'b0;
  reg I_RESET = 1'b1;
  reg done = 1'b0;
  reg mode = 1'b1;
  reg ce = 1'b1;
  wire gate;
  wire [10:0] cnt;
  reg [2:0] fm = 3'h0;
  wire valid;
  wire [11:0] code;
  wire [3:0] d_n;
  wire [3:0] oe;
  integer n_errors = 0;
  integer comparisons = 0;
  integer cyc = 0;
  reg [3:0] a;
  reg [3:0] b;
  // ==========
  // Clock, counted signal and timeout
  always #25 I_CLK_SYS = ~I_CLK_SYS;
  always @(posedge I_CLK_SYS) begin
    fm <= fm + 3'h1;
    cyc = cyc + 1;
    if (cyc == 6000) begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  gccc_counter i_gccc_counter (.I_CLK_SYS, .I_RESET, .i_ce(ce), .i_cmd_valid(valid), .i_cmd_code(code),
    .i_mode_select_flag(mode), .i_freq_mux_input(fm[2]), .i_conversion_done(done), .o_readback_d_n(d_n),
    .o_readback_oe(oe), .o_gate_active(gate), .o_clock_count(cnt), .o_cycle_count());
  gccc_ctrl_model i_gccc_ctrl_model (.I_CLK_SYS, .i_d_n(d_n), .i_oe(oe), .o_valid(valid), .o_code(code));
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task rd(input [11:0] c, output [3:0] n);
    begin
      i_gccc_ctrl_model.send(c);
      n = d_n;
    end
  endtask
  task volt_test;
    begin
      rd(`GCCC_CMD_ARM, a);
      rd(`GCCC_CMD_OPEN, a);
      repeat (2100) @(posedge I_CLK_SYS);
      done <= 1'b1;
      repeat (8) @(posedge I_CLK_SYS);
      chk("clkcry", i_gccc_ctrl_model.clk_carries, 1);
      chk("cyccry", i_gccc_ctrl_model.cyc_carries, 0);
      rd(`GCCC_CMD_OUT_EN, a);
      chk("outen", {oe, a}, 8'hFF);
      rd(`GCCC_CMD_SHIFT_CYC, a);
      chk("cyclo", a, 4'hF);
      rd(`GCCC_CMD_COPY_CLK1, a);
      rd(`GCCC_CMD_COPY_CLK2, b);
      chk("volt", ~{b, a} >= 8'd52 && ~{b, a} <= 8'd60, 1);
    end
  endtask
  task freq_test;
    begin
      mode <= 1'b0;
      rd(`GCCC_CMD_ARM, a);
      rd(`GCCC_CMD_OPEN, a);
      repeat (288) @(posedge I_CLK_SYS);
      rd(`GCCC_CMD_STOP, a);
      repeat (20) @(posedge I_CLK_SYS);
      chk("cyccry", i_gccc_ctrl_model.cyc_carries, 1);
      rd(`GCCC_CMD_OUT_EN, a);
      chk("cychi", a, 4'hF);
      rd(`GCCC_CMD_SHIFT_CYC, a);
      chk("freq", ~a >= 4'h2 && ~a <= 4'h6, 1);
    end
  endtask
  task ce_test;
    begin
      mode <= 1'b1;
      done <= 1'b0;
      rd(`GCCC_CMD_ARM, a);
      rd(`GCCC_CMD_OPEN, a);
      ce <= 1'b0;
      repeat (10) @(posedge I_CLK_SYS);
      chk("frozen", {gate, cnt}, 12'h801);
      ce <= 1'b1;
      repeat (5) @(posedge I_CLK_SYS);
      chk("resumed", cnt, 11'h005);
    end
  endtask
  task final_report;
    begin
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge I_CLK_SYS);
    I_RESET <= 1'b0;
    @(posedge I_CLK_SYS);
    chk("idle", {oe, d_n}, 8'h0F);
    volt_test;
    freq_test;
    ce_test;
    final_report;
  end
endmodule
bind gccc_counter gccc_counter_assertions i_gccc_counter_assertions (.I_CLK_SYS, .I_RESET, .i_ce, .i_cmd_valid,
  .i_cmd_code, .o_readback_d_n, .o_readback_oe, .o_gate_active, .o_clock_count, .o_cycle_count);
